// >>> logic/flash_prog_pkg.sv
`default_nettype none

package flash_prog_pkg;

   // ****************************************
   // clock and pin timing
   // ****************************************
   localparam int unsigned CLK_MHZ  = 50;
   localparam int unsigned WP_NS    = 90;
   localparam int unsigned WPH_NS   = 100;
   localparam int unsigned ACC_NS   = 150;
   localparam int unsigned OEHP_NS  = 150;
   localparam int unsigned BLC_US   = 150;
   localparam int unsigned WC_MS    = 10;
   // least times round up, longest times round down
   localparam int unsigned WP_CYC   = (WP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WPH_CYC  = (WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACC_CYC  = (ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned OEHP_CYC = (OEHP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BLC_CYC  = BLC_US * CLK_MHZ;
   localparam int unsigned WC_CYC   = WC_MS * 1000 * CLK_MHZ;

   // ****************************************
   // geometry
   // ****************************************
   localparam int unsigned SECTOR_BYTES = 128;
   localparam int unsigned SEQ_WORDS    = 3;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [9:0] OFS_CTRL     = 10'h000;
   localparam logic [9:0] OFS_STATUS   = 10'h004;
   localparam logic [9:0] OFS_SECTOR   = 10'h008;
   localparam logic [9:0] OFS_ADDR     = 10'h00c;
   localparam logic [9:0] OFS_RDATA    = 10'h010;
   localparam logic [9:0] OFS_KEY_ADDR = 10'h014;
   localparam logic [9:0] OFS_KEY_DATA = 10'h018;
   localparam logic [9:0] OFS_BUF      = 10'h200;

   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned CTRL_OP_LSB   = 0;
   localparam int unsigned CTRL_CODE_LSB = 8;
   localparam int unsigned KEY_ADDR2_LSB = 16;
   localparam int unsigned KEY_DATA2_LSB = 8;
   localparam int unsigned ST_BUSY_BIT   = 0;
   localparam int unsigned ST_DONE_BIT   = 1;
   localparam int unsigned ST_TOUT_BIT   = 2;
   localparam int unsigned ST_WERR_BIT   = 3;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [9:0]  SECTOR_RST   = 10'h000;
   localparam logic [16:0] ADDR_RST     = 17'h00000;
   localparam logic [14:0] KEY_ADDR_RST = 15'h0000;
   localparam logic [7:0]  KEY_DATA_RST = 8'h00;

   // ****************************************
   // operations
   // ****************************************
   localparam logic [3:0] OP_READ        = 4'h1;
   localparam logic [3:0] OP_READ_ID     = 4'h2;
   localparam logic [3:0] OP_SEQ         = 4'h3;
   localparam logic [3:0] OP_PROGRAM     = 4'h4;
   localparam logic [3:0] OP_SEQ_PROGRAM = 4'h5;

endpackage

`default_nettype wire

// >>> logic/flash_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none

module flash_bus_cycle (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // cycle request
   input  wire logic        i_start,
   input  wire logic        i_write,
   input  wire logic [16:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   output logic             o_done,
   output logic [7:0]       o_rdata,
   // flash pins
   output logic [16:0]      o_addr,
   output logic [7:0]       o_dq_out,
   output logic             o_dq_oe,
   input  wire logic [7:0]  i_dq_in,
   output logic             o_ce_n,
   output logic             o_oe_n,
   output logic             o_we_n
);

   typedef enum logic [2:0] {S_IDLE, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH} cyc_state_t;

   cyc_state_t state_reg;
   logic [3:0] cnt_reg;
   wire        cnt_zero = (cnt_reg == 4'h0);

   // ****************************************
   // one write or read cycle on the pins
   // ****************************************
   // oe stays high through every write so the pins never fight
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 4'h0;
         o_done    <= 1'b0;
         o_rdata   <= 8'h00;
         o_addr    <= 17'h00000;
         o_dq_out  <= 8'h00;
         o_dq_oe   <= 1'b0;
         o_ce_n    <= 1'b1;
         o_oe_n    <= 1'b1;
         o_we_n    <= 1'b1;
      end else begin
         o_done  <= 1'b0;
         cnt_reg <= cnt_reg - 4'h1;
         unique case (state_reg)
            S_IDLE: begin
               cnt_reg <= 4'h0;
               if (i_start) begin
                  o_addr <= i_addr;
                  o_ce_n <= 1'b0;
                  if (i_write) begin
                     o_dq_out  <= i_wdata;
                     o_dq_oe   <= 1'b1;
                     o_we_n    <= 1'b0;
                     cnt_reg   <= 4'(flash_prog_pkg::WP_CYC - 1);
                     state_reg <= S_WLOW;
                  end else begin
                     o_oe_n    <= 1'b0;
                     cnt_reg   <= 4'(flash_prog_pkg::ACC_CYC - 1);
                     state_reg <= S_RLOW;
                  end
               end
            end
            S_WLOW: begin
               if (cnt_zero) begin
                  // data latched on this rising edge; address held on
                  o_we_n    <= 1'b1;
                  o_ce_n    <= 1'b1;
                  cnt_reg   <= 4'(flash_prog_pkg::WPH_CYC - 1);
                  state_reg <= S_WHIGH;
               end
            end
            S_WHIGH: begin
               if (cnt_zero) begin
                  o_dq_oe   <= 1'b0;
                  o_done    <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_RLOW: begin
               if (cnt_zero) begin
                  o_rdata   <= i_dq_in;
                  o_oe_n    <= 1'b1;
                  o_ce_n    <= 1'b1;
                  cnt_reg   <= 4'(flash_prog_pkg::OEHP_CYC - 1);
                  state_reg <= S_RHIGH;
               end
            end
            S_RHIGH: begin
               if (cnt_zero) begin
                  o_done    <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> logic/sector_flash_host.sv
// Notes on behaviour
// - every byte load of a sector presents the same sector number on address bits 16..7.
// - each further byte load starts within 150 us of the one before it.
// - the protect-enable sequence is followed by a load of all 128 bytes of a sector.
// - status polling keeps one fixed address across all successive reads.
// - command words are bytes on data 7..0 and command addresses use bits 14..0 only.
`timescale 1ns/1ps
`default_nettype none

module sector_flash_host #(
   parameter int unsigned PROG_TIMEOUT_CYC = flash_prog_pkg::WC_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // register port
   input  wire logic [9:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic [31:0]      o_reg_rdata,
   // flash pins
   output logic [16:0]      o_flash_addr,
   output logic [7:0]       o_flash_dq_out,
   output logic             o_flash_dq_oe,
   input  wire logic [7:0]  i_flash_dq_in,
   output logic             o_flash_ce_n,
   output logic             o_flash_oe_n,
   output logic             o_flash_we_n
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_SEQ, ST_LOAD, ST_POLL1, ST_POLL2, ST_READ
   } host_state_t;

   // ****************************************
   // state
   // ****************************************
   host_state_t state_reg;
   logic [6:0]  idx_reg;
   logic        pend_reg;
   logic [3:0]  op_reg;
   logic [7:0]  code_reg;
   logic [9:0]  sector_reg;
   logic [16:0] addr_reg;
   logic [14:0] key_addr1_reg;
   logic [14:0] key_addr2_reg;
   logic [7:0]  key_data1_reg;
   logic [7:0]  key_data2_reg;
   logic [7:0]  rdata_reg;
   logic        done_reg;
   logic        timeout_reg;
   logic        werr_reg;
   logic        last_bit7_reg;
   logic        prev_bit6_reg;
   logic [31:0] prog_cnt_reg;
   logic [15:0] gap_cnt_reg;
   logic [7:0]  buf_reg [flash_prog_pkg::SECTOR_BYTES];

   // ****************************************
   // register decode
   // ****************************************
   wire       is_buf   = (i_reg_addr[9] == flash_prog_pkg::OFS_BUF[9]);
   wire [6:0] buf_idx  = i_reg_addr[8:2];
   wire       wr_ctrl  = i_reg_wr && (i_reg_addr == flash_prog_pkg::OFS_CTRL);
   wire [3:0] new_op   = i_reg_wdata[flash_prog_pkg::CTRL_OP_LSB +: 4];
   wire       op_legal = (new_op >= flash_prog_pkg::OP_READ)
                         && (new_op <= flash_prog_pkg::OP_SEQ_PROGRAM);
   wire       launch   = wr_ctrl && (state_reg == ST_IDLE) && op_legal;
   wire       busy     = (state_reg != ST_IDLE);

   wire [31:0] status_word = {28'h0000000, werr_reg, timeout_reg, done_reg, busy};
   wire [31:0] rd_mux =
      is_buf                                    ? {24'h000000, buf_reg[buf_idx]} :
      (i_reg_addr == flash_prog_pkg::OFS_CTRL)  ? {16'h0000, code_reg, 4'h0, op_reg} :
      (i_reg_addr == flash_prog_pkg::OFS_STATUS) ? status_word :
      (i_reg_addr == flash_prog_pkg::OFS_SECTOR) ? {22'h000000, sector_reg} :
      (i_reg_addr == flash_prog_pkg::OFS_ADDR)  ? {15'h0000, addr_reg} :
      (i_reg_addr == flash_prog_pkg::OFS_RDATA) ? {24'h000000, rdata_reg} :
      (i_reg_addr == flash_prog_pkg::OFS_KEY_ADDR) ?
         {1'b0, key_addr2_reg, 1'b0, key_addr1_reg} :
      (i_reg_addr == flash_prog_pkg::OFS_KEY_DATA) ?
         {16'h0000, key_data2_reg, key_data1_reg} :
      32'h00000000;

   // ****************************************
   // bus cycle request
   // ****************************************
   wire       bus_done;
   wire [7:0] bus_rdata;
   wire       need_bus  = busy;
   wire       bus_start = need_bus && !pend_reg && !bus_done;
   wire       bus_write = (state_reg == ST_SEQ) || (state_reg == ST_LOAD);
   wire       seq_last  = (idx_reg == 7'(flash_prog_pkg::SEQ_WORDS - 1));
   wire       load_last = (idx_reg == 7'(flash_prog_pkg::SECTOR_BYTES - 1));

   // command words carry only address bits 14..0
   wire [14:0] seq_addr  = (idx_reg == 7'd1) ? key_addr2_reg : key_addr1_reg;
   wire [7:0]  seq_data  = (idx_reg == 7'd0) ? key_data1_reg :
                           (idx_reg == 7'd1) ? key_data2_reg : code_reg;
   // identification reads hold bits 16..1 low, bit 0 picks the code
   wire [16:0] read_addr = (op_reg == flash_prog_pkg::OP_READ_ID) ?
                           {16'h0000, addr_reg[0]} : addr_reg;
   // one fixed poll location for the whole wait
   // last loaded byte, so line 7 is held against that byte's own bit 7
   wire [16:0] poll_addr = {sector_reg, 7'(flash_prog_pkg::SECTOR_BYTES - 1)};

   wire [16:0] bus_addr =
      (state_reg == ST_SEQ)  ? {2'b00, seq_addr} :
      (state_reg == ST_LOAD) ? {sector_reg, idx_reg} :
      (state_reg == ST_READ) ? read_addr : poll_addr;
   wire [7:0]  bus_wdata = (state_reg == ST_SEQ) ? seq_data : buf_reg[idx_reg];

   // finished when line 6 stops flipping and line 7 shows true data
   wire poll_stable  = (bus_rdata[6] == prev_bit6_reg)
                       && (bus_rdata[7] == last_bit7_reg);
   wire prog_expired = (prog_cnt_reg >= 32'(PROG_TIMEOUT_CYC));

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         op_reg        <= 4'h0;
         code_reg      <= 8'h00;
         sector_reg    <= flash_prog_pkg::SECTOR_RST;
         addr_reg      <= flash_prog_pkg::ADDR_RST;
         key_addr1_reg <= flash_prog_pkg::KEY_ADDR_RST;
         key_addr2_reg <= flash_prog_pkg::KEY_ADDR_RST;
         key_data1_reg <= flash_prog_pkg::KEY_DATA_RST;
         key_data2_reg <= flash_prog_pkg::KEY_DATA_RST;
      end else if (i_reg_wr && !busy) begin
         // settings are frozen while an operation runs
         if (launch) begin
            op_reg   <= new_op;
            code_reg <= i_reg_wdata[flash_prog_pkg::CTRL_CODE_LSB +: 8];
         end
         if (i_reg_addr == flash_prog_pkg::OFS_SECTOR) begin
            sector_reg <= i_reg_wdata[9:0];
         end
         if (i_reg_addr == flash_prog_pkg::OFS_ADDR) begin
            addr_reg <= i_reg_wdata[16:0];
         end
         if (i_reg_addr == flash_prog_pkg::OFS_KEY_ADDR) begin
            key_addr1_reg <= i_reg_wdata[14:0];
            key_addr2_reg <= i_reg_wdata[flash_prog_pkg::KEY_ADDR2_LSB +: 15];
         end
         if (i_reg_addr == flash_prog_pkg::OFS_KEY_DATA) begin
            key_data1_reg <= i_reg_wdata[7:0];
            key_data2_reg <= i_reg_wdata[flash_prog_pkg::KEY_DATA2_LSB +: 8];
         end
      end
   end

   // ****************************************
   // sector buffer
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < flash_prog_pkg::SECTOR_BYTES; g++) begin : g_buf
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               buf_reg[g] <= 8'h00;
            end else if (i_reg_wr && !busy && is_buf && (buf_idx == 7'(g))) begin
               buf_reg[g] <= i_reg_wdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h00000000;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // ****************************************
   // operation sequencer
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_reg <= 1'b0;
      end else if (bus_start) begin
         pend_reg <= 1'b1;
      end else if (bus_done) begin
         pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg     <= ST_IDLE;
         idx_reg       <= 7'h00;
         rdata_reg     <= 8'h00;
         last_bit7_reg <= 1'b0;
         prev_bit6_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               idx_reg <= 7'h00;
               if (launch) begin
                  if ((new_op == flash_prog_pkg::OP_READ)
                      || (new_op == flash_prog_pkg::OP_READ_ID)) begin
                     state_reg <= ST_READ;
                  end else if (new_op == flash_prog_pkg::OP_PROGRAM) begin
                     state_reg <= ST_LOAD;
                  end else begin
                     state_reg <= ST_SEQ;
                  end
               end
            end
            ST_SEQ: begin
               if (bus_done) begin
                  idx_reg <= seq_last ? 7'h00 : idx_reg + 7'h01;
                  if (seq_last) begin
                     // protect on/off needs a full sector load after it
                     state_reg <= (op_reg == flash_prog_pkg::OP_SEQ_PROGRAM) ?
                                  ST_LOAD : ST_IDLE;
                  end
               end
            end
            ST_LOAD: begin
               if (bus_done) begin
                  last_bit7_reg <= bus_wdata[7];
                  idx_reg       <= idx_reg + 7'h01;
                  // all 128 bytes go in so none is left undefined
                  if (load_last) begin
                     // loads stop here; the device then programs by itself
                     state_reg <= ST_POLL1;
                  end
               end
            end
            ST_POLL1: begin
               if (bus_done) begin
                  prev_bit6_reg <= bus_rdata[6];
                  state_reg     <= ST_POLL2;
               end
            end
            ST_POLL2: begin
               if (bus_done) begin
                  prev_bit6_reg <= bus_rdata[6];
                  // protection changes only take hold once this wait ends
                  if (poll_stable || prog_expired) begin
                     rdata_reg <= bus_rdata;
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_READ: begin
               if (bus_done) begin
                  rdata_reg <= bus_rdata;
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // status flags and timers
   // ****************************************
   // flags set at the end of an operation and clear on the next launch;
   // launch only happens while idle, so the two never collide
   wire finish = busy && bus_done && (state_reg != ST_LOAD)
                 && ((state_reg == ST_READ)
                     || ((state_reg == ST_SEQ) && seq_last
                         && (op_reg != flash_prog_pkg::OP_SEQ_PROGRAM))
                     || ((state_reg == ST_POLL2) && (poll_stable || prog_expired)));

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         done_reg    <= 1'b0;
         timeout_reg <= 1'b0;
      end else if (finish) begin
         done_reg    <= 1'b1;
         timeout_reg <= !poll_stable && prog_expired && (state_reg == ST_POLL2);
      end else if (launch) begin
         done_reg    <= 1'b0;
         timeout_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prog_cnt_reg <= 32'h00000000;
      end else if ((state_reg == ST_POLL1) || (state_reg == ST_POLL2)) begin
         prog_cnt_reg <= prog_expired ? prog_cnt_reg : prog_cnt_reg + 32'h00000001;
      end else begin
         prog_cnt_reg <= 32'h00000000;
      end
   end

   // gap between load starts must stay inside the load window
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_cnt_reg <= 16'h0000;
         werr_reg    <= 1'b0;
      end else if (launch) begin
         gap_cnt_reg <= 16'h0000;
         werr_reg    <= 1'b0;
      end else if (state_reg == ST_LOAD) begin
         gap_cnt_reg <= bus_start ? 16'h0000 : gap_cnt_reg + 16'h0001;
         if (bus_start && (gap_cnt_reg >= 16'(flash_prog_pkg::BLC_CYC))) begin
            werr_reg <= 1'b1;
         end
      end else begin
         gap_cnt_reg <= 16'h0000;
      end
   end

   // ****************************************
   // pin cycle engine
   // ****************************************
   flash_bus_cycle u_cycle (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_start  (bus_start),
      .i_write  (bus_write),
      .i_addr   (bus_addr),
      .i_wdata  (bus_wdata),
      .o_done   (bus_done),
      .o_rdata  (bus_rdata),
      .o_addr   (o_flash_addr),
      .o_dq_out (o_flash_dq_out),
      .o_dq_oe  (o_flash_dq_oe),
      .i_dq_in  (i_flash_dq_in),
      .o_ce_n   (o_flash_ce_n),
      .o_oe_n   (o_flash_oe_n),
      .o_we_n   (o_flash_we_n)
   );

endmodule

`default_nettype wire

// >>> test/flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module flash_model #(
   parameter int unsigned LOAD_WIN = flash_prog_pkg::BLC_CYC,
   parameter int unsigned PROG_CYC = 400,
   parameter logic [7:0]  MAKER    = 8'h3c, // arbitrary value
   parameter logic [7:0]  PART     = 8'hc3, // arbitrary value
   parameter logic [7:0]  ID_ENTER = 8'h90,
   parameter logic [7:0]  ID_EXIT  = 8'hf0
) (
   // host side pins
   input  wire logic        i_clk,
   input  wire logic [16:0] i_addr,
   input  wire logic [7:0]  i_dq,
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   output logic [7:0]       o_dq
);
   logic [7:0] mem [int];
   logic [7:0] ld [128];
   logic [9:0] sec = '0;
   logic [7:0] w1 = '0, w2 = '0, last = '0, q = '0;
   int         nload = 0, idle = 0, busy = 0;
   bit         idm = 0, tog = 0, pwe = 1, poe = 1, rd_go;
   assign o_dq = q;
   always @(posedge i_clk) begin
      rd_go = poe && !i_oe_n && !i_ce_n;
      if (pwe && !i_we_n && !i_ce_n && busy == 0) begin
         if (w1 == 8'haa && w2 == 8'h55 && i_dq == ID_ENTER) idm = 1;
         if (w1 == 8'haa && w2 == 8'h55 && i_dq == ID_EXIT) idm = 0;
         w1 = w2;
         w2 = i_dq;
         last = i_dq;
         sec = i_addr[16:7];
         ld[i_addr[6:0]] = i_dq;
         nload++;
         idle = 0;
      // a read also closes the load phase, so polls never see stale array data
      end else if (nload > 0 && (++idle >= LOAD_WIN || rd_go)) begin
         if (nload > 3) begin
            // latches left stale stand for bytes that were not loaded
            for (int i = 0; i < 128; i++) begin
               mem[{sec, i[6:0]}] = ld[i];
               ld[i] = ~ld[i];
            end
            busy = PROG_CYC;
         end
         nload = 0;
      end
      if (rd_go && busy > 0) tog = ~tog;
      if (rd_go) q <= (busy > 0) ? {~last[7], tog, 6'h00} :
         (idm && i_addr[15:1] == 15'h0000) ? (i_addr[0] ? PART : MAKER) :
         mem.exists(i_addr) ? mem[i_addr] : 8'hff;
      else if (i_oe_n || i_ce_n) q <= ~q;
      if (busy > 0) busy--;
      pwe = i_we_n;
      poe = i_oe_n;
   end
endmodule

`default_nettype wire

// >>> test/sector_flash_host_props.sv
`timescale 1ns/1ps
`default_nettype none

module sector_flash_host_props (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // flash pins
   input  wire logic [16:0] o_flash_addr,
   input  wire logic        o_flash_dq_oe,
   input  wire logic        o_flash_ce_n,
   input  wire logic        o_flash_oe_n,
   input  wire logic        o_flash_we_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_wlow; !o_flash_we_n && $stable(o_flash_addr); endsequence
   sequence s_rlow; !o_flash_oe_n && $stable(o_flash_addr) && !o_flash_dq_oe; endsequence
   property p_load; $fell(o_flash_we_n) |-> !o_flash_we_n ##1 s_wlow[*4] ##1 o_flash_we_n;
   endproperty
   property p_read; $fell(o_flash_oe_n) |-> !o_flash_ce_n ##1 s_rlow[*7] ##1 o_flash_oe_n;
   endproperty
   property p_excl; !(!o_flash_we_n && !o_flash_oe_n); endproperty
   property p_dq_we; !o_flash_we_n |-> o_flash_dq_oe && !o_flash_ce_n; endproperty
   property p_wr_hold; $rose(o_flash_we_n) |-> (o_flash_dq_oe && $stable(o_flash_addr))[*5];
   endproperty
   property p_oehp; $rose(o_flash_oe_n) |-> o_flash_oe_n[*8]; endproperty
   property p_gap; $rose(o_flash_ce_n) |-> o_flash_ce_n[*5]; endproperty
   property p_idle; o_flash_ce_n |-> o_flash_oe_n && o_flash_we_n; endproperty
   a_load: assert property (p_load) else $error("address moved in write pulse");
   a_read: assert property (p_read) else $error("bad read strobe");
   a_excl: assert property (p_excl) else $error("oe and we low together");
   a_dq_we: assert property (p_dq_we) else $error("write without data drive");
   a_wr_hold: assert property (p_wr_hold) else $error("data or address dropped");
   a_oehp: assert property (p_oehp) else $error("oe high pulse short");
   a_gap: assert property (p_gap) else $error("ce high gap short");
   a_idle: assert property (p_idle) else $error("strobe low while deselected");
endmodule

bind sector_flash_host sector_flash_host_props sector_flash_host_props_i (.i_clk, .i_rst,
   .o_flash_addr, .o_flash_dq_oe, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n);

`default_nettype wire

// >>> test/sector_flash_host_test.sv
`timescale 1ns/1ps
`default_nettype none

module sector_flash_host_test;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [9:0]  ra = '0;
   logic [31:0] wd = '0;
   logic        wr = 1'b0, rs = 1'b0;
   logic [31:0] rdat, v, lfsr = 32'hc4d2;
   logic [16:0] fa;
   logic [7:0]  fdo, fdi;
   logic        foe, fce, fo, fw;
   logic [9:0]  sec;
   logic [7:0]  exp_q [$];
   int          errors = 0, cmp_count = 0;
   // ****************************************
   // harness
   // ****************************************
   initial forever #10 i_clk = ~i_clk;
   flash_model flash_model_i (.i_clk(i_clk), .i_addr(fa), .i_dq(fdo), .i_ce_n(fce),
      .i_oe_n(fo), .i_we_n(fw), .o_dq(fdi));
   sector_flash_host #(.PROG_TIMEOUT_CYC(2000)) sector_flash_host_i (.i_clk(i_clk),
      .i_rst(i_rst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rs),
      .o_reg_rdata(rdat), .o_flash_addr(fa), .o_flash_dq_out(fdo), .o_flash_dq_oe(foe),
      .i_flash_dq_in(fdi), .o_flash_ce_n(fce), .o_flash_oe_n(fo), .o_flash_we_n(fw));
   function logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(input logic [9:0] a, input logic [31:0] d);
      @(posedge i_clk) begin ra <= a; wd <= d; wr <= 1'b1; end
      @(posedge i_clk) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [9:0] a, output logic [31:0] d);
      @(posedge i_clk) begin ra <= a; rs <= 1'b1; end
      @(posedge i_clk) rs <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic waitdone();
      int n;
      n = 0;
      v = 32'h1;
      while (v[0] !== 1'b0 && n < 3000) begin rreg(flash_prog_pkg::OFS_STATUS, v); n++; end
      if (n == 3000) chk("busy", 32'h0, v);
   endtask
   task automatic op(input logic [3:0] c, input logic [7:0] b);
      wreg(flash_prog_pkg::OFS_CTRL, {16'h0000, b, 4'h0, c});
      waitdone();
   endtask
   task automatic rdbyte(input logic [16:0] a);
      wreg(flash_prog_pkg::OFS_ADDR, {15'h0000, a});
      op(flash_prog_pkg::OP_READ, 8'h00);
      rreg(flash_prog_pkg::OFS_RDATA, v);
   endtask
   task automatic prog(input logic [3:0] c);
      v = rnd();
      sec = v[9:0];
      exp_q = {};
      wreg(flash_prog_pkg::OFS_SECTOR, {22'h0, sec});
      for (int i = 0; i < 128; i++) begin
         v = rnd();
         exp_q.push_back(v[7:0]);
         wreg(flash_prog_pkg::OFS_BUF + 10'(4 * i), {24'h0, v[7:0]});
      end
      wreg(flash_prog_pkg::OFS_CTRL, {16'h0000, 8'ha0, 4'h0, c});
      wreg(flash_prog_pkg::OFS_SECTOR, {22'h0, ~sec});
      waitdone();
      rreg(flash_prog_pkg::OFS_SECTOR, v);
      chk("sector", {22'h0, sec}, v);
      rreg(flash_prog_pkg::OFS_STATUS, v);
      chk("status", 32'h2, v);
      for (int i = 0; i < 128; i++) begin
         rdbyte({sec, 7'(i)});
         chk("array", {24'h0, exp_q[i]}, v);
      end
      $display("test program op %0d done", c);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      rreg(flash_prog_pkg::OFS_STATUS, v);
      chk("status", 32'h0, v);
      rreg(flash_prog_pkg::OFS_SECTOR, v);
      chk("sector", 32'h0, v);
      rreg(10'h100, v);
      chk("unmapped", 32'h0, v);
      rreg(flash_prog_pkg::OFS_BUF, v);
      chk("buffer", 32'h0, v);
      $display("test reset done");
      wreg(flash_prog_pkg::OFS_KEY_ADDR, {1'b0, 15'h2aaa, 1'b0, 15'h5555});
      wreg(flash_prog_pkg::OFS_KEY_DATA, 32'h000055aa);
      prog(flash_prog_pkg::OP_PROGRAM);
      prog(flash_prog_pkg::OP_SEQ_PROGRAM);
      op(flash_prog_pkg::OP_SEQ, 8'h90);
      for (int i = 0; i < 2; i++) begin
         wreg(flash_prog_pkg::OFS_ADDR, 32'(i));
         op(flash_prog_pkg::OP_READ_ID, 8'h00);
         rreg(flash_prog_pkg::OFS_RDATA, v);
         chk("id", (i == 1) ? 32'hc3 : 32'h3c, v);
      end
      op(flash_prog_pkg::OP_SEQ, 8'hf0);
      rdbyte({sec, 7'h00});
      chk("array", {24'h0, exp_q[0]}, v);
      $display("test identification done");
      wreg(flash_prog_pkg::OFS_CTRL, 32'h0);
      rreg(flash_prog_pkg::OFS_STATUS, v);
      chk("idle", 32'h0, {31'h0, v[0]});
      $display("test bad op done");
      finish_test();
   end
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
endmodule

`default_nettype wire
